// File: bench/board_model.sv
// Board reset circuit with pull-up, and interrupt source
`timescale 1ns/1ps
module board_model (
  input wire logic pull_rst,
  input wire logic nmi_low,
  input wire logic reset_in_n_o,
  input wire logic reset_in_n_oe,
  output logic reset_in_n_i,
  output logic nmi_n
);
  assign reset_in_n_i = !pull_rst && !(reset_in_n_oe && !reset_in_n_o);
  assign nmi_n = !nmi_low;
endmodule : board_model

// File: bench/rst_sys_assertions.sv
// Checker for the reset, NMI and power-down block
`timescale 1ns/1ps
`include "rst_sys_regs.svh"
module rst_sys_checker #(
  parameter int RST_MIN = `RST_MIN_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic reset_in_n_i,
  input wire logic reset_in_n_oe,
  input wire logic reset_indication_out_n,
  input wire logic nmi_n,
  input wire logic nmi_trap_req,
  input wire logic end_of_init_instr,
  input wire logic powerdown_return_pin,
  input wire logic async_reset_sel,
  input wire logic wdt_reset
);
  // Holds checks off until the synchronised reset has settled
  logic [2:0] up_q;
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn) up_q <= 3'h0;
    else if (!up_q[2]) up_q <= up_q + 3'h1;
  // Counts cycles of the reset pin held low from outside
  logic [15:0] low_q;
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn) low_q <= 16'h0;
    else if (reset_in_n_i || reset_in_n_oe) low_q <= 16'h0;
    else if (low_q != 16'hffff) low_q <= low_q + 16'h1;
  // Marks the data phase of a command write
  logic cmd_ph_q;
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn) cmd_ph_q <= 1'b0;
    else cmd_ph_q <= hsel && hready && htrans[1] && hwrite
                     && haddr == `OFS_CMD;
  wire bus_eoi = cmd_ph_q && hwdata[`BIT_CMD_EOI];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!up_q[2]);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");
  pin_reset_a: assert property (
    low_q == 16'(RST_MIN) |-> ##[1:3] !reset_indication_out_n)
    else $error("pin low, no reset");
  drive_in_reset_a: assert property (
    reset_in_n_oe |-> !reset_indication_out_n)
    else $error("pin driven outside reset");
  wdt_ind_a: assert property (
    wdt_reset |-> ##[1:3] !reset_indication_out_n)
    else $error("watchdog reset not indicated");
  init_release_a: assert property (
    $rose(reset_indication_out_n) |-> $past(end_of_init_instr)
    || $past(end_of_init_instr, 2) || $past(bus_eoi))
    else $error("indication released without end of init");
  nmi_trap_a: assert property (
    $fell(nmi_n) && reset_indication_out_n |-> ##3 nmi_trap_req)
    else $error("no trap after falling edge");
  trap_cause_a: assert property (
    nmi_trap_req |-> $past(nmi_n, 4) && !$past(nmi_n, 3))
    else $error("trap without falling edge");
  trap_once_a: assert property (
    nmi_trap_req |=> !nmi_trap_req) else $error("trap pulse too long");
  ret_sel_a: assert property (
    async_reset_sel == $past(powerdown_return_pin))
    else $error("reset type does not follow return pin");
endmodule : rst_sys_checker
bind rst_sys rst_sys_checker #(.RST_MIN(RST_MIN)) rst_sys_checker_inst (.*);

// File: bench/testbench.sv
// Self-checking bench for the reset, NMI and power-down block
`timescale 1ns/1ps
`include "rst_sys_regs.svh"
module testbench;
  logic core_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic end_of_init_instr, powerdown_instr, wdt_reset;
  logic [2:0] strobe = 3'h0;
  localparam logic [2:0] EOI = 3'h1, PDN = 3'h2, WDT = 3'h4;
  assign end_of_init_instr = strobe[0];
  assign powerdown_instr = strobe[1];
  assign wdt_reset = strobe[2];
  logic powerdown_return_pin = 1'b1, pull_rst = 1'b0, nmi_low = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hready, hreadyout, hresp, reset_in_n_i, reset_in_n_o, reset_in_n_oe;
  logic reset_indication_out_n, nmi_n, nmi_trap_req, powerdown_active;
  logic async_reset_sel, slow_osc_off;
  int bad_count = 0, checks = 0, traps = 0;
  assign hready = hreadyout;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) traps <= traps + int'(nmi_trap_req === 1'b1);
  rst_sys #(.RST_MIN(2), .INT_RST(4)) rst_sys_inst (.*);
  board_model board_model_inst (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic pulse(input logic [2:0] which, input int n);
    strobe <= which;
    @(posedge core_clk);
    strobe <= 3'h0;
    repeat (n) @(posedge core_clk);
  endtask : pulse
  task automatic give_verdict();
    $display("Mismatches %0d of %0d checks", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, `CTRL_RST);
    repeat (10) @(posedge core_clk);
    chk(reset_indication_out_n, 1'b0);
    pulse(EOI, 3);
    chk(reset_indication_out_n, 1'b1);
    bus(1'b1, `OFS_CTRL, 32'h5);
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, 32'h5);
    chk(slow_osc_off, 1'b1);
    bus(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `OFS_CMD, 32'h4);
    @(posedge core_clk);
    chk(reset_in_n_oe, 1'b1);
    repeat (12) @(posedge core_clk);
    chk(reset_in_n_oe, 1'b0);
    pulse(EOI, 3);
    pulse(WDT, 3);
    chk(reset_indication_out_n, 1'b0);
    repeat (10) @(posedge core_clk);
    pulse(EOI, 3);
    pulse(PDN, 4);
    chk(powerdown_active, 1'b0);
    nmi_low <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk(traps, 1);
    pulse(PDN, 4);
    chk(powerdown_active, 1'b1);
    powerdown_return_pin <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(async_reset_sel, 1'b0);
    chk(powerdown_active, 1'b1);
    pull_rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    pull_rst <= 1'b0;
    chk(reset_indication_out_n, 1'b0);
    chk(powerdown_active, 1'b0);
    powerdown_return_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(async_reset_sel, 1'b1);
    repeat (4) @(posedge core_clk);
    bus(1'b1, `OFS_CMD, 32'h1);
    @(posedge core_clk);
    chk(reset_indication_out_n, 1'b1);
    bus(1'b1, `OFS_CTRL, 32'h2);
    nmi_low <= 1'b0;
    bus(1'b1, `OFS_CMD, 32'h2);
    @(posedge core_clk);
    chk(powerdown_active, 1'b1);
    bus(1'b0, `OFS_STAT, 32'h0);
    chk(rd, 32'h7);
    chk(slow_osc_off, 1'b0);
    powerdown_return_pin <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(powerdown_active, 1'b0);
    nmi_low <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk(traps, 2);
    give_verdict();
  end
endmodule : testbench

// File: core/rst_sys.sv
// Reset, NMI trap and power-down sequencing with AHB-Lite registers
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "rst_sys_regs.svh"
module rst_sys #(
  parameter int RST_MIN = `RST_MIN_CYC,
  parameter int INT_RST = `INT_RST_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic reset_in_n_i,
  output logic reset_in_n_o,
  output logic reset_in_n_oe,
  output logic reset_indication_out_n,
  input wire logic nmi_n,
  output logic nmi_trap_req,
  input wire logic end_of_init_instr,
  input wire logic powerdown_instr,
  input wire logic powerdown_return_pin,
  output logic powerdown_active,
  output logic async_reset_sel,
  output logic slow_osc_off,
  input wire logic wdt_reset
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic ph_wr_q, ph_rd_q;
  logic [11:0] ph_addr_q;
  logic [31:0] ctrl_q;
  logic cmd_eoi, cmd_pd, cmd_swrst;
  logic [31:0] stat;
  rst_sys_pkg::sys_state_type state_q;
  logic pin_rst;
  wire take = hsel && hready && htrans[1];
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ph_wr_q <= 1'b0;
      ph_rd_q <= 1'b0;
      ph_addr_q <= 12'h000;
    end else begin
      ph_wr_q <= take && hwrite;
      ph_rd_q <= take && !hwrite;
      ph_addr_q <= haddr;
    end
  end
  // Zero-wait slave, every transfer answered OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= `CTRL_RST;
    end else if (ph_wr_q && ph_addr_q == `OFS_CTRL) begin
      // R8 oscillator-off bit
      ctrl_q <= {29'h0, hwdata[2:0]};
    end
  end
  assign cmd_eoi = ph_wr_q && ph_addr_q == `OFS_CMD && hwdata[`BIT_CMD_EOI];
  assign cmd_pd = ph_wr_q && ph_addr_q == `OFS_CMD && hwdata[`BIT_CMD_PD];
  assign cmd_swrst = ph_wr_q && ph_addr_q == `OFS_CMD
                     && hwdata[`BIT_CMD_SWRST];
  always_comb begin
    stat = 32'h0;
    stat[`BIT_ST_INDIC] = reset_indication_out_n;
    stat[`BIT_ST_PD] = powerdown_active;
    stat[`BIT_ST_ASYNC] = async_reset_sel;
    stat[`BIT_ST_INTRST] = (state_q == rst_sys_pkg::st_reset);
  end
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      case (haddr)
        `OFS_CTRL: begin
          // Forward a write still in its data phase
          if (ph_wr_q && ph_addr_q == `OFS_CTRL) begin
            hrdata <= {29'h0, hwdata[2:0]};
          end else begin
            hrdata <= ctrl_q;
          end
        end
        `OFS_STAT: hrdata <= stat;
        default: hrdata <= 32'h0;
      endcase
    end
  end
  assign slow_osc_off = ctrl_q[`BIT_OSCOFF];

  // ----------------------------------------------------------------
  // Reset input filter
  // ----------------------------------------------------------------
  // The count is held at zero while the device drives the pin itself, so its own
  // reset pulse is never taken for an external one
  logic [15:0] low_cnt_q;
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      low_cnt_q <= 16'h0;
    end else if (reset_in_n_i || reset_in_n_oe) begin
      low_cnt_q <= 16'h0;
    end else if (low_cnt_q != 16'(RST_MIN)) begin
      low_cnt_q <= low_cnt_q + 16'h1;
    end
  end
  // R1 minimum low time
  assign pin_rst = low_cnt_q == 16'(RST_MIN);
  // R9 reset type select
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      async_reset_sel <= 1'b0;
    end else begin
      async_reset_sel <= powerdown_return_pin;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [15:0] seq_cnt_q;
  logic nmi_s1_q, nmi_s2_q, nmi_prev_q;
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= rst_sys_pkg::st_reset;
      seq_cnt_q <= 16'h0;
    end else if (pin_rst || cmd_swrst || wdt_reset) begin
      state_q <= rst_sys_pkg::st_reset;
      seq_cnt_q <= 16'h0;
    end else begin
      case (state_q)
        rst_sys_pkg::st_reset: begin
          if (seq_cnt_q == 16'(INT_RST)) begin
            state_q <= rst_sys_pkg::st_wait_init;
          end else begin
            seq_cnt_q <= seq_cnt_q + 16'h1;
          end
        end
        rst_sys_pkg::st_wait_init: begin
          // R4 release on end-of-init
          if (end_of_init_instr || cmd_eoi) begin
            state_q <= rst_sys_pkg::st_run;
          end
        end
        rst_sys_pkg::st_run: begin
          // R6 R7 entry gated by NMI when config 0
          if ((powerdown_instr || cmd_pd)
              && (ctrl_q[`BIT_POWERDOWN_CONFIG_BIT] || !nmi_s2_q)) begin
            state_q <= rst_sys_pkg::st_powerdown;
          end
        end
        rst_sys_pkg::st_powerdown: begin
          // R9 wake on return pin when config 1
          if (ctrl_q[`BIT_POWERDOWN_CONFIG_BIT] && !powerdown_return_pin) begin
            state_q <= rst_sys_pkg::st_run;
          end
        end
        default: state_q <= rst_sys_pkg::st_reset;
      endcase
    end
  end
  // R2 drive reset line in bidirectional mode
  assign reset_in_n_oe = ctrl_q[`BIT_BIDIR]
                         && state_q == rst_sys_pkg::st_reset;
  assign reset_in_n_o = 1'b0;
  // R3 low during any reset
  // Falls on the edge that enters reset, so the pin is never driven
  // while the indication still shows run
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reset_indication_out_n <= 1'b0;
    end else if (pin_rst || cmd_swrst || wdt_reset) begin
      reset_indication_out_n <= 1'b0;
    end else if (state_q == rst_sys_pkg::st_wait_init
                 && (end_of_init_instr || cmd_eoi)) begin
      // R4 released with the sequencer
      reset_indication_out_n <= 1'b1;
    end
  end
  assign powerdown_active = state_q == rst_sys_pkg::st_powerdown;

  // ----------------------------------------------------------------
  // NMI edge detect
  // ----------------------------------------------------------------
  // R10 synchronise NMI
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      nmi_s1_q <= 1'b1;
      nmi_s2_q <= 1'b1;
      nmi_prev_q <= 1'b1;
    end else begin
      nmi_s1_q <= nmi_n;
      nmi_s2_q <= nmi_s1_q;
      nmi_prev_q <= nmi_s2_q;
    end
  end
  // R5 one trap per falling edge
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      nmi_trap_req <= 1'b0;
    end else begin
      nmi_trap_req <= nmi_prev_q && !nmi_s2_q;
    end
  end
endmodule : rst_sys

// File: core/rst_sys_pkg.sv
// Types for the reset, NMI and power-down block
package rst_sys_pkg;
  typedef enum logic [1:0] {
    st_run,
    st_reset,
    st_wait_init,
    st_powerdown
  } sys_state_type;
endpackage : rst_sys_pkg

// File: core/rst_sys_regs.svh
// Register offsets, field positions, reset values and timing counts
// Summary of operation
// R1 - Low reset input for minimum time resets
// R2 - Bidirectional mode drives reset line during reset
// R3 - Indication output low in every reset
// R4 - Indication stays low until end-of-init executes
// R5 - Falling NMI edge requests trap routine
// R6 - Power-down entry needs NMI low when config 0
// R7 - NMI high, config 0: power-down ignored
// R8 - Software sets oscillator-off bit when unused
// R9 - Return pin: powerdown wake and reset type
// R10 - Synchronise NMI; one trap per edge
`ifndef RST_SYS_REGS_SVH
`define RST_SYS_REGS_SVH
`define OFS_CTRL 12'h000
`define OFS_STAT 12'h004
`define OFS_CMD 12'h008
`define BIT_BIDIR 0
`define BIT_POWERDOWN_CONFIG_BIT 1
`define BIT_OSCOFF 2
`define CTRL_RST 32'h00000000
`define BIT_ST_INDIC 0
`define BIT_ST_PD 1
`define BIT_ST_ASYNC 2
`define BIT_ST_INTRST 3
`define BIT_CMD_EOI 0
`define BIT_CMD_PD 1
`define BIT_CMD_SWRST 2
`define RST_MIN_NS 100
`define RST_MIN_CYC ((`RST_MIN_NS + 3) / 4)
`define INT_RST_NS 1000
`define INT_RST_CYC ((`INT_RST_NS + 3) / 4)
`endif
